/* File: design/cief_defs.vh */
`ifndef CIEF_DEFS_VH
`define CIEF_DEFS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define CIEF_ADDR_W          9
`define CIEF_CTRL_LOW        7'h0b
`define CIEF_ADDR_CTRL0      9'h00b
`define CIEF_ADDR_CTRL1      9'h08b
`define CIEF_ADDR_CTRL2      9'h10b
`define CIEF_ADDR_CTRL3      9'h18b
`define CIEF_ADDR_PFLAGS_A   9'h00c
`define CIEF_ADDR_PFLAGS_B   9'h00d
`define CIEF_ADDR_EVT_STAT   9'h1e0
`define CIEF_ADDR_EVT_MASK   9'h1e1

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CIEF_BIT_GLOBAL_EN   7
`define CIEF_BIT_PERIPH_EN   6
`define CIEF_BIT_TICK_EN     5
`define CIEF_BIT_EXT_EN      4
`define CIEF_BIT_PORT_EN     3
`define CIEF_BIT_TICK_FLAG   2
`define CIEF_BIT_EXT_FLAG    1
`define CIEF_BIT_PORT_FLAG   0

// ----------------------------------------------------------------
// Event status fields
// ----------------------------------------------------------------
`define CIEF_EVT_W           4
`define CIEF_EVT_TICK        0
`define CIEF_EVT_EXT         1
`define CIEF_EVT_PORT        2
`define CIEF_EVT_PERIPH      3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CIEF_RST_CTRL_HI     7'h00
`define CIEF_RST_PORT_COLD   1'b0
`define CIEF_RST_PFLAGS_A    8'h00
`define CIEF_RST_PFLAGS_B    1'b0
`define CIEF_RST_EVT         4'h0
`define CIEF_PRIME_CYCLES    2'h3

`endif

/* File: design/cief_top.v */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "cief_defs.vh"

module cief_top (
    // Clock, reset and enable
    input  wire                     ref_clk,
    input  wire                     reset,
    input  wire                     resetIsCold,
    input  wire                     clkEn,
    // Register port
    input  wire [`CIEF_ADDR_W-1:0]  regAddr,
    input  wire [7:0]               regWrData,
    input  wire                     regWr,
    input  wire                     regRd,
    output reg  [7:0]               regRdData_q,
    // Event sources
    input  wire                     tickOverflow,
    input  wire                     extIrqPin,
    input  wire                     extRisingEdge,
    input  wire [3:0]               upperPortPins,
    input  wire [7:0]               periphReqA,
    input  wire                     periphReqB,
    // Peripheral enables
    input  wire [7:0]               periphEnA,
    input  wire                     periphEnB,
    // Requests
    output reg                      coreIrqReq_q,
    output reg                      irqOut_q
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function isCtrlAddr;
        input [`CIEF_ADDR_W-1:0] addr;
        begin
            isCtrlAddr = (addr[6:0] == `CIEF_CTRL_LOW);
        end
    endfunction

    function anyGated;
        input [7:0] flags;
        input [7:0] enables;
        begin
            anyGated = |(flags & enables);
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg  [7:0]              ctrl_q;
    reg  [7:0]              ctrl_d;
    reg  [7:0]              pFlagsA_q;
    reg  [7:0]              pFlagsA_d;
    reg                     pFlagsB_q;
    reg                     pFlagsB_d;
    reg  [`CIEF_EVT_W-1:0]  evtStat_q;
    reg  [`CIEF_EVT_W-1:0]  evtStat_d;
    reg  [`CIEF_EVT_W-1:0]  evtMask_q;
    reg  [`CIEF_EVT_W-1:0]  evtMask_d;
    reg  [7:0]              rdData_d;
    reg                     coreIrqReq_d;
    reg                     irqOut_d;

    reg                     extMeta_q;
    reg                     extSync_q;
    reg                     extPrev_q;
    reg  [3:0]              portMeta_q;
    reg  [3:0]              portSync_q;
    reg  [3:0]              portPrev_q;
    reg  [1:0]              primeCnt_q;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire ctrlSel   = isCtrlAddr(regAddr);
    wire pASel     = (regAddr == `CIEF_ADDR_PFLAGS_A);
    wire pBSel     = (regAddr == `CIEF_ADDR_PFLAGS_B);
    wire statSel   = (regAddr == `CIEF_ADDR_EVT_STAT);
    wire maskSel   = (regAddr == `CIEF_ADDR_EVT_MASK);

    wire ctrlWr    = regWr & ctrlSel;
    wire pAWr      = regWr & pASel;
    wire pBWr      = regWr & pBSel;
    wire statWr    = regWr & statSel;
    wire maskWr    = regWr & maskSel;

    // ------------------------------------------------------------
    // Source events
    // ------------------------------------------------------------
    wire primed    = (primeCnt_q == `CIEF_PRIME_CYCLES);

    // Edge polarity is chosen by the core's option logic
    wire extEdge   = primed & (extRisingEdge ?
                     (extSync_q & ~extPrev_q) :
                     (~extSync_q & extPrev_q));

    wire portEvt   = primed & (|(portSync_q ^ portPrev_q));

    wire tickEvt   = tickOverflow;

    wire periphEvt = (|periphReqA) | periphReqB;

    // ------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------
    always @* begin
        ctrl_d = ctrl_q;
        if (ctrlWr) begin
            ctrl_d = regWrData;
        end
        // Hardware set wins over a software clear
        if (tickEvt) begin
            ctrl_d[`CIEF_BIT_TICK_FLAG] = 1'b1;
        end
        if (extEdge) begin
            ctrl_d[`CIEF_BIT_EXT_FLAG] = 1'b1;
        end
        if (portEvt) begin
            ctrl_d[`CIEF_BIT_PORT_FLAG] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Peripheral flag registers next value
    // ------------------------------------------------------------
    always @* begin
        pFlagsA_d = pFlagsA_q;
        pFlagsB_d = pFlagsB_q;
        if (pAWr) begin
            pFlagsA_d = regWrData;
        end
        if (pBWr) begin
            pFlagsB_d = regWrData[0];
        end
        pFlagsA_d = pFlagsA_d | periphReqA;
        pFlagsB_d = pFlagsB_d | periphReqB;
    end

    // ------------------------------------------------------------
    // Event status and mask next value
    // ------------------------------------------------------------
    always @* begin
        evtStat_d = evtStat_q;
        evtMask_d = evtMask_q;
        if (statWr) begin
            evtStat_d = evtStat_q & ~regWrData[`CIEF_EVT_W-1:0];
        end
        if (maskWr) begin
            evtMask_d = regWrData[`CIEF_EVT_W-1:0];
        end
        evtStat_d[`CIEF_EVT_TICK]   = evtStat_d[`CIEF_EVT_TICK]
                                      | tickEvt;
        evtStat_d[`CIEF_EVT_EXT]    = evtStat_d[`CIEF_EVT_EXT]
                                      | extEdge;
        evtStat_d[`CIEF_EVT_PORT]   = evtStat_d[`CIEF_EVT_PORT]
                                      | portEvt;
        evtStat_d[`CIEF_EVT_PERIPH] = evtStat_d[`CIEF_EVT_PERIPH]
                                      | periphEvt;
    end

    // ------------------------------------------------------------
    // Request to the core
    // ------------------------------------------------------------
    wire [7:0] coreFlags = {5'h00, ctrl_d[`CIEF_BIT_TICK_FLAG],
                            ctrl_d[`CIEF_BIT_EXT_FLAG],
                            ctrl_d[`CIEF_BIT_PORT_FLAG]};
    wire [7:0] coreEns   = {5'h00, ctrl_d[`CIEF_BIT_TICK_EN],
                            ctrl_d[`CIEF_BIT_EXT_EN],
                            ctrl_d[`CIEF_BIT_PORT_EN]};

    wire coreHit   = anyGated(coreFlags, coreEns);
    wire periphHit = ctrl_d[`CIEF_BIT_PERIPH_EN]
                     & (anyGated(pFlagsA_d, periphEnA)
                        | (pFlagsB_d & periphEnB));

    always @* begin
        coreIrqReq_d = ctrl_d[`CIEF_BIT_GLOBAL_EN]
                       & (coreHit | periphHit);
        irqOut_d     = |(evtStat_d & evtMask_d);
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always @* begin
        rdData_d = 8'h00;
        if (regRd) begin
            if (ctrlSel) begin
                rdData_d = ctrl_q;
            end else if (pASel) begin
                rdData_d = pFlagsA_q;
            end else if (pBSel) begin
                rdData_d = {7'h00, pFlagsB_q};
            end else if (statSel) begin
                rdData_d = {4'h0, evtStat_q};
            end else if (maskSel) begin
                rdData_d = {4'h0, evtMask_q};
            end else begin
                rdData_d = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and change tracking
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            extMeta_q  <= 1'b0;
            extSync_q  <= 1'b0;
            extPrev_q  <= 1'b0;
            portMeta_q <= 4'h0;
            portSync_q <= 4'h0;
            portPrev_q <= 4'h0;
            primeCnt_q <= 2'h0;
        end else if (clkEn) begin
            extMeta_q  <= extIrqPin;
            extSync_q  <= extMeta_q;
            extPrev_q  <= extSync_q;
            portMeta_q <= upperPortPins;
            portSync_q <= portMeta_q;
            portPrev_q <= portSync_q;
            // Hold off change detection until the chain is full
            if (!primed) begin
                primeCnt_q <= primeCnt_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            ctrl_q[7:1]  <= `CIEF_RST_CTRL_HI;
            if (resetIsCold) begin
                ctrl_q[`CIEF_BIT_PORT_FLAG] <= `CIEF_RST_PORT_COLD;
            end
            pFlagsA_q    <= `CIEF_RST_PFLAGS_A;
            pFlagsB_q    <= `CIEF_RST_PFLAGS_B;
            evtStat_q    <= `CIEF_RST_EVT;
            evtMask_q    <= `CIEF_RST_EVT;
            regRdData_q  <= 8'h00;
            coreIrqReq_q <= 1'b0;
            irqOut_q     <= 1'b0;
        end else if (clkEn) begin
            ctrl_q       <= ctrl_d;
            pFlagsA_q    <= pFlagsA_d;
            pFlagsB_q    <= pFlagsB_d;
            evtStat_q    <= evtStat_d;
            evtMask_q    <= evtMask_d;
            regRdData_q  <= rdData_d;
            coreIrqReq_q <= coreIrqReq_d;
            irqOut_q     <= irqOut_d;
        end
    end

endmodule // cief_top

/* File: bench/cief_top_sva.sv */
`timescale 1ns/1ps
module cief_top_chk (
    // Clock and reset
    input wire       ref_clk,
    input wire       reset,
    input wire       resetIsCold,
    input wire       clkEn,
    // Register port
    input wire [8:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWr,
    input wire       regRd,
    input wire [7:0] regRdData_q,
    // Requests
    input wire       coreIrqReq_q,
    input wire       irqOut_q
);
    wire ctrlWrNow = clkEn && regWr && regAddr[6:0] == 7'h0b;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence ctrlWr;
        ctrlWrNow;
    endsequence
    sequence ctrlRd;
        clkEn && regRd && regAddr[6:0] == 7'h0b;
    endsequence
    property mirror_p;
        logic [7:0] d;
        (ctrlWr, d = regWrData) ##1 !ctrlWrNow ##1 ctrlRd
            |=> regRdData_q[7:3] == d[7:3];
    endproperty
    AST_MIRROR: assert property (mirror_p)
        else $error("control enables not read back");
    AST_FLAGS_B_ZERO: assert property (clkEn && regRd &&
        regAddr == 9'h00d |=> regRdData_q[7:1] == 7'h00)
        else $error("flags b upper bits not zero");
    AST_REQ_HELD: assert property ($fell(coreIrqReq_q) |->
        $past(regWr) || $past(reset))
        else $error("core request dropped without a write");
    AST_IRQ_HELD: assert property ($fell(irqOut_q) |->
        $past(regWr) || $past(reset))
        else $error("interrupt dropped without a write");
    AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=>
        !coreIrqReq_q && !irqOut_q && regRdData_q == 8'h00)
        else $error("outputs active after reset");
    AST_COLD_CTRL: assert property (disable iff (1'b0)
        reset && resetIsCold ##1 !reset ##1 ctrlRd |=>
        regRdData_q[7:3] == 5'h00 && !regRdData_q[0])
        else $error("control not clear after cold reset");
    AST_GIE_BLOCK: assert property (ctrlWr ##0 !regWrData[7]
        ##1 !ctrlWrNow |=> !coreIrqReq_q)
        else $error("request with global enable clear");
    AST_NO_ENABLE: assert property (ctrlWr ##0 regWrData[6:3] == 4'h0
        ##1 !ctrlWrNow |=> !coreIrqReq_q)
        else $error("request with no source enabled");
endmodule // cief_top_chk

/* File: bench/cief_src_model.sv */
`timescale 1ns/1ps
module cief_src_model (
    // Clock
    input wire         ref_clk,
    // Event sources
    output logic       tickOverflow,
    output logic       extIrqPin,
    output logic [3:0] upperPortPins,
    output logic [7:0] periphReqA,
    output logic       periphReqB
);
    initial begin
        tickOverflow = 1'b0;
        extIrqPin = 1'b0;
        upperPortPins = 4'h0;
        periphReqA = 8'h00;
        periphReqB = 1'b0;
    end
    // One-cycle request pulses
    task pulse(input logic t, input logic [7:0] a, input logic b);
        @(posedge ref_clk);
        tickOverflow <= t;
        periphReqA <= a;
        periphReqB <= b;
        @(posedge ref_clk);
        tickOverflow <= 1'b0;
        periphReqA <= 8'h00;
        periphReqB <= 1'b0;
    endtask
    task pins(input logic e, input logic [3:0] p);
        @(posedge ref_clk);
        extIrqPin <= e;
        upperPortPins <= p;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule // cief_src_model

/* File: bench/cief_top_tb_top.sv */
`timescale 1ns/1ps
module cief_top_tb_top;
    logic       ref_clk, reset, resetIsCold, clkEn, regWr, regRd;
    logic       extRisingEdge, periphEnB;
    logic [8:0] regAddr;
    logic [7:0] regWrData, periphEnA, rdv;
    wire  [7:0] regRdData_q, periphReqA;
    wire  [3:0] upperPortPins;
    wire        coreIrqReq_q, irqOut_q, tickOverflow, extIrqPin, periphReqB;
    int         mismatches, checks_done;
    cief_top cief_top_i (.ref_clk, .reset, .resetIsCold, .clkEn, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData_q, .tickOverflow, .extIrqPin,
        .extRisingEdge, .upperPortPins, .periphReqA, .periphReqB, .periphEnA,
        .periphEnB, .coreIrqReq_q, .irqOut_q);
    cief_src_model src (.ref_clk, .tickOverflow, .extIrqPin, .upperPortPins,
        .periphReqA, .periphReqB);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task rdchk(input logic [8:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk(regRdData_q, e);
    endtask
    task outchk(input logic [1:0] e);
        @(posedge ref_clk);
        #1 chk({6'h00, coreIrqReq_q, irqOut_q}, {6'h00, e});
    endtask
    task do_reset(input logic cold);
        @(posedge ref_clk);
        reset <= 1'b1;
        resetIsCold <= cold;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        do_reset(1'b1);
        rdchk(9'h00b, 8'h00);
        rdchk(9'h00c, 8'h00);
        rdchk(9'h00d, 8'h00);
        rdchk(9'h1e0, 8'h00);
        rdchk(9'h1ff, 8'h00);
        $display("reset test done");
    endtask
    task t_tick;
        wr(9'h00b, 8'h00);
        src.pulse(1'b1, 8'h00, 1'b0);
        rdchk(9'h08b, 8'h04);
        wr(9'h00b, 8'h84);
        outchk(2'b00);
        wr(9'h10b, 8'ha4);
        rdchk(9'h08b, 8'ha4);
        outchk(2'b10);
        rdchk(9'h18b, 8'ha4);
        wr(9'h1e1, 8'h01);
        outchk(2'b11);
        wr(9'h1e0, 8'h01);
        outchk(2'b10);
        wr(9'h00b, 8'h20);
        outchk(2'b00);
        $display("tick test done");
    endtask
    task t_ext;
        @(posedge ref_clk);
        extRisingEdge <= 1'b1;
        src.pins(1'b1, 4'h0);
        rdchk(9'h00b, 8'h22);
        wr(9'h00b, 8'h92);
        outchk(2'b10);
        wr(9'h00b, 8'h00);
        @(posedge ref_clk);
        extRisingEdge <= 1'b0;
        src.pins(1'b0, 4'h0);
        rdchk(9'h00b, 8'h02);
        $display("edge test done");
    endtask
    task t_port;
        wr(9'h00b, 8'h00);
        src.pins(1'b0, 4'h8);
        rdchk(9'h00b, 8'h01);
        wr(9'h00b, 8'h89);
        outchk(2'b10);
        wr(9'h00b, 8'h08);
        src.pins(1'b0, 4'h0);
        do_reset(1'b0);
        rdchk(9'h00b, 8'h01);
        $display("port test done");
    endtask
    task t_periph;
        for (int i = 0; i < 8; i++) begin
            src.pulse(1'b0, 8'h01 << i, 1'b0);
            rdchk(9'h00c, 8'h01 << i);
            wr(9'h00c, 8'h00);
        end
        @(posedge ref_clk);
        periphEnA <= 8'h40;
        src.pulse(1'b0, 8'h40, 1'b1);
        wr(9'h00b, 8'hc0);
        outchk(2'b10);
        rdchk(9'h00d, 8'h01);
        wr(9'h00d, 8'hfe);
        rdchk(9'h00d, 8'h00);
        $display("peripheral test done");
    endtask
    initial begin
        {reset, resetIsCold, clkEn} = 3'b111;
        {regWr, regRd, extRisingEdge, periphEnB} = 4'h1;
        regAddr = 9'h000;
        regWrData = 8'h00;
        periphEnA = 8'h00;
        mismatches = 0;
        checks_done = 0;
        t_reset();
        t_tick();
        t_ext();
        t_port();
        t_periph();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        print_verdict();
    end
endmodule // cief_top_tb_top
bind cief_top cief_top_chk cief_top_chk_i (.ref_clk, .reset, .resetIsCold,
    .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q,
    .coreIrqReq_q, .irqOut_q);
